// *** logic/ccoe_defs.vh ***
// Constants for the clock output enable control block.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef CCOE_DEFS_VH
`define CCOE_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define CCOE_IDX_OECR_HI     5'h00
`define CCOE_IDX_OECR_LO     5'h01
`define CCOE_IDX_OECR_MID    5'h02
`define CCOE_IDX_PIN_RDBK    5'h03
`define CCOE_IDX_SEL_RDBK    5'h04
`define CCOE_IDX_VENDOR      5'h05
`define CCOE_IDX_DEVICE      5'h06
`define CCOE_IDX_BYTE_CNT    5'h07
`define CCOE_IDX_MASK_HI     5'h08
`define CCOE_IDX_MASK_LO     5'h09
`define CCOE_IDX_MASK_MID    5'h0A
`define CCOE_IDX_STATUS      5'h10
`define CCOE_IDX_RUN_STATE   5'h11
`define CCOE_IDX_NONE        5'h1F

// Reset values.
`define CCOE_RST_OECR_HI     8'h78
`define CCOE_RST_OECR_LO     8'hFF
`define CCOE_RST_OECR_MID    8'hFF
`define CCOE_RST_MASK        8'h00
`define CCOE_RST_BYTE_CNT    8'h08

// Identification values are arbitrary.
`define CCOE_VENDOR_ID       8'h11
`define CCOE_DEVICE_ID       8'h22

// High byte register field: channels 19..16 sit in bits 6..3.
`define CCOE_HI_LSB          3
`define CCOE_HI_MSB          6

// Three-level strap codes.
`define CCOE_STRAP_LOW       2'h0
`define CCOE_STRAP_MID       2'h1
`define CCOE_STRAP_HIGH      2'h2

// Status register field positions.
`define CCOE_ST_SMB_ACTIVE   0
`define CCOE_ST_PGOOD        1
`define CCOE_ST_PDOWN        2
`define CCOE_ST_ADDR_LSB     8

// Bus responses.
`define CCOE_RESP_OKAY       2'h0
`define CCOE_RESP_SLVERR     2'h2

`define CCOE_NUM_CH          20

`endif

// *** logic/ccoe_sbi_rx.v ***
// Sideband serial receiver: shift register and its output register.
// Assumes the three sideband lines arrive already synchronised to aclk.
`timescale 1ns/1ps

module ccoe_sb_rx
(
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // Synchronised sideband lines and path select
   input  wire        sb_active,
   input  wire        sb_data,
   input  wire        sb_clk,
   input  wire        sb_load_n,
   // Loaded channel enables
   output wire [19:0] sb_out
);

   reg  [19:0] shift_q;
   reg  [19:0] out_q;
   reg         clk_prev_q;
   reg         load_prev_q;
   wire        clk_rise;
   wire        load_fall;

   assign clk_rise  = sb_clk & ~clk_prev_q;
   assign load_fall = ~sb_load_n & load_prev_q;
   assign sb_out    = out_q;

   // The link clock is sampled, not used as a clock, so its period must stay well above
   // two aclk periods for each edge to be seen.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         shift_q     <= 20'h00000;
         out_q       <= 20'h00000;
         clk_prev_q  <= 1'b1;
         load_prev_q <= 1'b1;
      end
      else
      begin
         clk_prev_q  <= sb_clk;
         load_prev_q <= sb_load_n;
         if (sb_active && clk_rise && sb_load_n)
         begin
            shift_q <= {shift_q[18:0], sb_data};
         end
         if (sb_active && load_fall)
         begin
            out_q <= shift_q;
         end
      end
   end

endmodule

// *** logic/ccoe_top.v ***
// Clock output enable control: register path, enable pins, sideband path, power state.
// Assumes an AXI4-Lite master on aclk and asynchronous board-level pins.
`timescale 1ns/1ps
`include "ccoe_defs.vh"

module ccoe_top
(
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // Board pins
   input  wire        power_good_down_pin,
   input  wire        sideband_select_pin,
   input  wire [12:5] oe_n_pin,
   input  wire [1:0]  address_strap_upper,
   input  wire [1:0]  address_strap_lower,
   // Channel states, bus active flag and bus address
   output wire [19:0] clock_output_run,
   output wire        clock_output_hiz,
   output wire        smbus_active,
   output wire [7:0]  smbus_address
);

   localparam [31:0] ZERO32 = 32'h00000000;
   localparam [7:0]  RST_HI = `CCOE_RST_OECR_HI;
   localparam [7:0]  RST_MK = `CCOE_RST_MASK;

   // Synchronisers: stage one feeds stage two only.
   reg  [11:0] sync1_q;
   reg  [11:0] sync2_q;
   wire [11:0] pins_raw;
   wire        pgd_s;
   wire        sel_s;
   wire [12:5] oe_n_s;
   wire [1:0]  strap_up_s;
   wire [1:0]  strap_lo_s;
   reg  [1:0]  strap_up_1q;
   reg  [1:0]  strap_up_2q;
   reg  [1:0]  strap_lo_1q;
   reg  [1:0]  strap_lo_2q;

   // Power state and address.
   reg         pgd_prev_q;
   reg         power_good_latch_q;
   reg         power_down_flag_q;
   reg         bus_open_q;
   reg  [7:0]  addr_q;

   // Register file.
   reg  [19:0] channel_enable_bit_q;
   reg  [19:0] mask_q;
   reg  [7:0]  byte_cnt_q;

   // Bus slave state.
   reg         awready_q;
   reg         wready_q;
   reg         aw_full_q;
   reg         w_full_q;
   reg  [4:0]  aw_idx_q;
   reg  [7:0]  wdata_q;
   reg         wlane_q;
   reg         bvalid_q;
   reg  [1:0]  bresp_q;
   reg         arready_q;
   reg         rvalid_q;
   reg  [1:0]  rresp_q;
   reg  [31:0] rdata_q;
   wire [4:0]  ar_idx;
   wire        bus_open;

   // Channel decision and output.
   wire [19:0] sb_out;
   wire [19:0] dec_run;
   reg  [19:0] dec_run_q;
   reg         dec_hiz_q;
   wire        dec_hiz;
   reg  [19:0] run_q;
   reg         hiz_q;

   // Maps a byte address onto a register index, or none.
   function [4:0] ccoe_idx;
      input [31:0] addr;
      reg   [4:0]  idx;
      begin
         idx = addr[6:2];
         if (addr[31:7] != 25'h0000000)
            ccoe_idx = `CCOE_IDX_NONE;
         else if (idx <= `CCOE_IDX_MASK_MID)
            ccoe_idx = idx;
         else if (idx == `CCOE_IDX_STATUS)
            ccoe_idx = idx;
         else if (idx == `CCOE_IDX_RUN_STATE)
            ccoe_idx = idx;
         else
            ccoe_idx = `CCOE_IDX_NONE;
      end
   endfunction

   // Decodes the two three-level straps into a bus address.
   function [7:0] ccoe_addr;
      input [1:0] up;
      input [1:0] lo;
      begin
         if (up == `CCOE_STRAP_LOW && lo == `CCOE_STRAP_LOW)
            ccoe_addr = 8'hD8;
         else if (up == `CCOE_STRAP_LOW && lo == `CCOE_STRAP_MID)
            ccoe_addr = 8'hDA;
         else if (up == `CCOE_STRAP_LOW)
            ccoe_addr = 8'hDE;
         else if (up == `CCOE_STRAP_MID && lo == `CCOE_STRAP_LOW)
            ccoe_addr = 8'hC2;
         else if (up == `CCOE_STRAP_MID && lo == `CCOE_STRAP_MID)
            ccoe_addr = 8'hC4;
         else if (up == `CCOE_STRAP_MID)
            ccoe_addr = 8'hC6;
         else if (lo == `CCOE_STRAP_LOW)
            ccoe_addr = 8'hCA;
         else if (lo == `CCOE_STRAP_MID)
            ccoe_addr = 8'hCC;
         else
            ccoe_addr = 8'hCE;
      end
   endfunction

   // Register read view for one index.
   function [31:0] ccoe_rd;
      input [4:0] idx;
      input [19:0] en;
      input [19:0] msk;
      begin
         if (idx == `CCOE_IDX_OECR_HI)
            ccoe_rd = {25'h0000000, en[19:16], 3'h0};
         else if (idx == `CCOE_IDX_OECR_LO)
            ccoe_rd = {24'h000000, en[7:0]};
         else if (idx == `CCOE_IDX_OECR_MID)
            ccoe_rd = {24'h000000, en[15:8]};
         else if (idx == `CCOE_IDX_MASK_HI)
            ccoe_rd = {25'h0000000, msk[19:16], 3'h0};
         else if (idx == `CCOE_IDX_MASK_LO)
            ccoe_rd = {24'h000000, msk[7:0]};
         else if (idx == `CCOE_IDX_MASK_MID)
            ccoe_rd = {24'h000000, msk[15:8]};
         else
            ccoe_rd = ZERO32;
      end
   endfunction

   assign pins_raw   = {power_good_down_pin, sideband_select_pin, oe_n_pin, 2'h0};
   assign pgd_s      = sync2_q[11];
   assign sel_s      = sync2_q[10];
   assign oe_n_s     = sync2_q[9:2];
   assign strap_up_s = strap_up_2q;
   assign strap_lo_s = strap_lo_2q;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_q     <= 12'h3FC;
         sync2_q     <= 12'h3FC;
         strap_up_1q <= 2'h0;
         strap_up_2q <= 2'h0;
         strap_lo_1q <= 2'h0;
         strap_lo_2q <= 2'h0;
      end
      else
      begin
         sync1_q     <= pins_raw;
         sync2_q     <= sync1_q;
         strap_up_1q <= address_strap_upper;
         strap_up_2q <= strap_up_1q;
         strap_lo_1q <= address_strap_lower;
         strap_lo_2q <= strap_lo_1q;
      end
   end

   // Reset stands for loss of supply, the only thing that clears the latch.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pgd_prev_q         <= 1'b0;
         bus_open_q         <= 1'b0;
         power_good_latch_q <= 1'b0;
         power_down_flag_q  <= 1'b0;
         addr_q             <= 8'h00;
      end
      else
      begin
         pgd_prev_q <= pgd_s;
         bus_open_q <= power_good_latch_q & pgd_s;
         if (!power_good_latch_q && pgd_s && !pgd_prev_q)
         begin
            power_good_latch_q <= 1'b1;
            addr_q             <= ccoe_addr(strap_up_s, strap_lo_s);
         end
         if (power_good_latch_q)
         begin
            power_down_flag_q <= ~pgd_s;
         end
      end
   end

   assign bus_open = bus_open_q;
   assign ar_idx   = ccoe_idx(s_axi_araddr);

   // Write side: address and data are taken in either order, the response follows both.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q            <= 1'b1;
         wready_q             <= 1'b1;
         aw_full_q            <= 1'b0;
         w_full_q             <= 1'b0;
         aw_idx_q             <= `CCOE_IDX_NONE;
         wdata_q              <= 8'h00;
         wlane_q              <= 1'b0;
         bvalid_q             <= 1'b0;
         bresp_q              <= `CCOE_RESP_OKAY;
         channel_enable_bit_q <= {RST_HI[6:3], `CCOE_RST_OECR_MID, `CCOE_RST_OECR_LO};
         mask_q               <= {RST_MK[6:3], RST_MK, RST_MK};
         byte_cnt_q           <= `CCOE_RST_BYTE_CNT;
      end
      else
      begin
         if (awready_q && s_axi_awvalid)
         begin
            aw_full_q <= 1'b1;
            awready_q <= 1'b0;
            aw_idx_q  <= ccoe_idx(s_axi_awaddr);
         end
         if (wready_q && s_axi_wvalid)
         begin
            w_full_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
         end
         if (aw_full_q && w_full_q && !bvalid_q)
         begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            if (!bus_open || aw_idx_q == `CCOE_IDX_NONE)
            begin
               bresp_q <= `CCOE_RESP_SLVERR;
            end
            else
            begin
               bresp_q <= `CCOE_RESP_OKAY;
               if (wlane_q)
               begin
                  if (aw_idx_q == `CCOE_IDX_OECR_HI)
                     channel_enable_bit_q[19:16] <= wdata_q[6:3];
                  else if (aw_idx_q == `CCOE_IDX_OECR_LO)
                     channel_enable_bit_q[7:0] <= wdata_q;
                  else if (aw_idx_q == `CCOE_IDX_OECR_MID)
                     channel_enable_bit_q[15:8] <= wdata_q;
                  else if (aw_idx_q == `CCOE_IDX_BYTE_CNT)
                     byte_cnt_q <= wdata_q;
                  else if (aw_idx_q == `CCOE_IDX_MASK_HI)
                     mask_q[19:16] <= wdata_q[6:3];
                  else if (aw_idx_q == `CCOE_IDX_MASK_LO)
                     mask_q[7:0] <= wdata_q;
                  else if (aw_idx_q == `CCOE_IDX_MASK_MID)
                     mask_q[15:8] <= wdata_q;
               end
            end
         end
         if (bvalid_q && s_axi_bready)
         begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // Read side: one cycle from address to data.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rresp_q   <= `CCOE_RESP_OKAY;
         rdata_q   <= ZERO32;
      end
      else
      begin
         if (arready_q && s_axi_arvalid)
         begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            if (!bus_open || ar_idx == `CCOE_IDX_NONE)
            begin
               rresp_q <= `CCOE_RESP_SLVERR;
               rdata_q <= ZERO32;
            end
            else
            begin
               rresp_q <= `CCOE_RESP_OKAY;
               if (ar_idx == `CCOE_IDX_PIN_RDBK)
                  rdata_q <= {24'h000000, oe_n_s};
               else if (ar_idx == `CCOE_IDX_SEL_RDBK)
                  rdata_q <= {31'h00000000, sel_s};
               else if (ar_idx == `CCOE_IDX_VENDOR)
                  rdata_q <= {24'h000000, `CCOE_VENDOR_ID};
               else if (ar_idx == `CCOE_IDX_DEVICE)
                  rdata_q <= {24'h000000, `CCOE_DEVICE_ID};
               else if (ar_idx == `CCOE_IDX_BYTE_CNT)
                  rdata_q <= {24'h000000, byte_cnt_q};
               else if (ar_idx == `CCOE_IDX_STATUS)
                  rdata_q <= {16'h0000, addr_q, 5'h00, power_down_flag_q,
                              power_good_latch_q, bus_open};
               else if (ar_idx == `CCOE_IDX_RUN_STATE)
                  rdata_q <= {11'h000, hiz_q, run_q};
               else
                  rdata_q <= ccoe_rd(ar_idx, channel_enable_bit_q, mask_q);
            end
         end
         if (rvalid_q && s_axi_rready)
         begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // The sideband path ignores the power pin so it can be set up before power-good.
   ccoe_sb_rx u_sb_rx
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .sb_active (sel_s),
      .sb_data   (oe_n_s[5]),
      .sb_clk    (oe_n_s[6]),
      .sb_load_n (oe_n_s[10]),
      .sb_out    (sb_out)
   );

   // Per-channel decision; pin gating only exists on channels 5 to 12.
   genvar ch;
   generate
      for (ch = 0; ch < `CCOE_NUM_CH; ch = ch + 1)
      begin : g_ch
         wire pin_ok;
         wire reg_path;
         wire sb_path;
         if (ch >= 5 && ch <= 12)
         begin : g_pin
            assign pin_ok = ~oe_n_s[ch];
         end
         else
         begin : g_nopin
            assign pin_ok = 1'b1;
         end
         assign reg_path    = channel_enable_bit_q[ch] & pin_ok;
         assign sb_path     = sb_out[ch] | mask_q[ch];
         assign dec_run[ch] = power_good_latch_q & ~power_down_flag_q &
                              (sel_s ? sb_path : reg_path);
      end
   endgenerate

   assign dec_hiz = power_good_latch_q & power_down_flag_q;

   // A decision reaches the outputs only once it held for two cycles, so a pin bounce or a
   // path switch never produces a runt enable.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dec_run_q <= 20'h00000;
         dec_hiz_q <= 1'b0;
         run_q     <= 20'h00000;
         hiz_q     <= 1'b0;
      end
      else
      begin
         dec_run_q <= dec_run;
         dec_hiz_q <= dec_hiz;
         if (dec_run == dec_run_q && dec_hiz == dec_hiz_q)
         begin
            run_q <= dec_run_q;
            hiz_q <= dec_hiz_q;
         end
      end
   end

   assign s_axi_awready    = awready_q;
   assign s_axi_wready     = wready_q;
   assign s_axi_bresp      = bresp_q;
   assign s_axi_bvalid     = bvalid_q;
   assign s_axi_arready    = arready_q;
   assign s_axi_rdata      = rdata_q;
   assign s_axi_rresp      = rresp_q;
   assign s_axi_rvalid     = rvalid_q;
   assign clock_output_run = run_q;
   assign clock_output_hiz = hiz_q;
   assign smbus_active     = bus_open_q;
   assign smbus_address    = addr_q;

endmodule

// *** testbench/ccoe_properties.sv ***
// Port assertions for the clock output enable control top.
// Assumes binding onto ccoe_top, one clock domain and a synchronous low reset.
`timescale 1ns/1ps
`include "ccoe_defs.vh"

module ccoe_chk
(
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Bus handshakes
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire [1:0]  s_axi_rresp,
   input wire [31:0] s_axi_rdata,
   // Channel and power state
   input wire [19:0] clock_output_run,
   input wire        clock_output_hiz,
   input wire        smbus_active,
   input wire [7:0]  smbus_address
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_hiz_run_off: assert property
      (clock_output_hiz |-> clock_output_run == 20'h00000)
      else $error("Channels run while tristated");
   a_addr_held: assert property
      (smbus_address != 8'h00 |=> $stable(smbus_address))
      else $error("Address moved after it was fixed");
   a_addr_legal: assert property
      (smbus_address != 8'h00 |-> smbus_address inside
       {8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE})
      else $error("Address outside the nine codes");
   a_nolatch_low: assert property
      (smbus_address == 8'h00 |-> clock_output_run == 20'h00000 && !clock_output_hiz)
      else $error("Outputs not low before power good");
   a_rd_closed: assert property
      (s_axi_arvalid && s_axi_arready && !smbus_active |=>
       s_axi_rvalid && s_axi_rresp == `CCOE_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("Read served while bus closed");
   a_wr_closed: assert property
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !smbus_active
       ##1 !smbus_active |=> s_axi_bvalid && s_axi_bresp == `CCOE_RESP_SLVERR)
      else $error("Write served while bus closed");
   a_run_steady: assert property
      ($changed(clock_output_run) |=> $stable(clock_output_run))
      else $error("Channel outputs changed on two edges in a row");
   a_hiz_latched: assert property
      (clock_output_hiz |-> smbus_address != 8'h00)
      else $error("Tristate before power good");

   c_hiz: cover property (clock_output_hiz);
   c_refused: cover property (s_axi_rvalid && s_axi_rresp == `CCOE_RESP_SLVERR);
   c_last_addr: cover property (smbus_address == 8'hCE);
endmodule

bind ccoe_top ccoe_chk u_chk
(
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rresp, .s_axi_rdata, .clock_output_run, .clock_output_hiz, .smbus_active,
   .smbus_address
);

// *** testbench/ccoe_sb_ctrl.sv ***
// Sideband serial controller model driving data, clock and load lines.
// Assumes the bench routes these lines onto the shared enable pins.
`timescale 1ns/1ps

module ccoe_sb_ctrl
(
   // Sideband lines
   output reg sb_data,
   output reg sb_clk,
   output reg sb_load_n
);
   reg busy;

   initial
   begin
      sb_data = 1'b0;
      sb_clk = 1'b0;
      sb_load_n = 1'b1;
      busy = 1'b0;
   end

   // Between frames the data line is not held, so it toggles instead of keeping a stale bit.
   always #400
      if (!busy)
         sb_data = ~sb_data;

   task automatic send(input logic [19:0] v, input logic slow);
      int i;
      begin
         busy = 1'b1;
         for (i = 19; i >= 0; i--)
         begin
            sb_data = v[i];
            #(slow ? 300 : 200);
            sb_clk = 1'b1;
            #400;
            sb_clk = 1'b0;
            #(slow ? 100 : 200);
         end
         sb_load_n = 1'b0;
         #800;
         sb_load_n = 1'b1;
         busy = 1'b0;
      end
   endtask
endmodule

// *** testbench/tb_clock_output_enable_control.sv ***
// Self-checking bench for the clock output enable control block.
// Assumes the checker and the sideband controller model are compiled first.
`timescale 1ns/1ps
`include "ccoe_defs.vh"

module tb_clock_output_enable_control;
   localparam logic [1:0] OK  = `CCOE_RESP_OKAY;
   localparam logic [1:0] SLV = `CCOE_RESP_SLVERR;
   reg          aclk = 1'b0;
   reg          aresetn = 1'b0;
   reg  [31:0]  awaddr = 32'h0;
   reg  [31:0]  wdata = 32'h0;
   reg  [31:0]  araddr = 32'h0;
   reg          awvalid = 1'b0;
   reg          wvalid = 1'b0;
   reg          bready = 1'b0;
   reg          arvalid = 1'b0;
   reg          rready = 1'b0;
   reg          pin_q = 1'b0;
   reg          sel_q = 1'b0;
   reg  [12:5]  oe_q = 8'hFF;
   reg  [1:0]   up_q = 2'h0;
   reg  [1:0]   lo_q = 2'h0;
   wire         awready, wready, bvalid, arready, rvalid, hiz, act, sb_dt, sb_ck, sb_ld;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [19:0]  run;
   wire [7:0]   adr;
   wire [12:5]  oe_n = sel_q ? {oe_q[12:11], sb_ld, oe_q[9:7], sb_ck, sb_dt} : oe_q;
   logic [33:0] rsp_q[$];
   logic [28:0] st_q[$];
   logic        look = 1'b0;
   int          err_total = 0;
   int          n_checks = 0;
   int          i;
   logic [31:0] rng = 32'h64F6D7EF;
   logic [31:0] r;
   logic [19:0] en_v, mk_v;
   logic [7:0]  atab [0:8] = '{8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE};

   always #50 aclk = ~aclk;

   ccoe_top uut
   (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .power_good_down_pin(pin_q), .sideband_select_pin(sel_q), .oe_n_pin(oe_n),
      .address_strap_upper(up_q), .address_strap_lower(lo_q), .clock_output_run(run),
      .clock_output_hiz(hiz), .smbus_active(act), .smbus_address(adr)
   );

   ccoe_sb_ctrl sb (.sb_data(sb_dt), .sb_clk(sb_ck), .sb_load_n(sb_ld));

   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   function automatic logic [19:0] exp_run(input logic [19:0] e, input logic [12:5] o);
      exp_run = e;
      exp_run[12:5] = e[12:5] & ~o;
   endfunction

   task automatic stop_test();
      begin
         $display("Checks %0d, errors %0d", n_checks, err_total);
         if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   task automatic tmo();
      begin
         err_total++;
         $display("Error at %0t: no bus answer", $time);
         stop_test();
      end
   endtask

   task automatic cmp_rsp(input logic [33:0] g, input logic [33:0] e);
      begin
         n_checks++;
         if (g !== e)
         begin
            err_total++;
            $display("Error at %0t: bus answer %h, expected %h", $time, g, e);
         end
      end
   endtask

   task automatic cmp_st(input logic [28:0] g, input logic [28:0] e);
      begin
         n_checks++;
         if (g !== e)
         begin
            err_total++;
            $display("Error at %0t: channel state %h, expected %h", $time, g, e);
         end
      end
   endtask

   // Write and read both hold every request until its own ready edge, as the bus demands.
   task automatic axw(input logic [31:0] a, input logic [7:0] d, input logic [1:0] rs);
      int n;
      begin
         rsp_q.push_back({rs, 32'h0});
         awaddr <= a;
         wdata <= {24'h0, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         for (n = 0; n < 40; n++)
         begin
            @(posedge aclk);
            if (awready)
               awvalid <= 1'b0;
            if (wready)
               wvalid <= 1'b0;
            if (bvalid)
               break;
         end
         if (n == 40)
            tmo();
      end
   endtask

   task automatic axr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] rs);
      int n;
      begin
         rsp_q.push_back({rs, rs == OK ? {24'h0, d} : 32'h0});
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         for (n = 0; n < 40; n++)
         begin
            @(posedge aclk);
            if (arready)
               arvalid <= 1'b0;
            if (rvalid)
               break;
         end
         if (n == 40)
            tmo();
      end
   endtask

   task automatic wr20(input logic [31:0] b, input logic [19:0] v);
      begin
         axw(b, {1'b0, v[19:16], 3'h0}, OK);
         axw(b + 32'h4, v[7:0], OK);
         axw(b + 32'h8, v[15:8], OK);
      end
   endtask

   // Pins pass two synchronisers and a stability filter, so twelve cycles cover the settle.
   task automatic chk_st(input logic h, input logic [19:0] v, input logic [7:0] a);
      begin
         st_q.push_back({h, v, a});
         repeat (12) @(posedge aclk);
         look <= 1'b1;
         @(posedge aclk);
         look <= 1'b0;
      end
   endtask

   task automatic rst(input logic [1:0] u, input logic [1:0] l);
      begin
         aresetn <= 1'b0;
         pin_q <= 1'b0;
         up_q <= u;
         lo_q <= l;
         repeat (12) @(posedge aclk);
         aresetn <= 1'b1;
         repeat (4) @(posedge aclk);
      end
   endtask

   always @(posedge aclk)
   begin
      if ((bvalid && bready) || (rvalid && rready))
         cmp_rsp(rvalid ? {rresp, rdata} : {bresp, 32'h0}, rsp_q.pop_front());
      if (look)
         cmp_st({hiz, run, adr}, st_q.pop_front());
   end

   initial
   begin
      @(posedge aclk);
      rst(2'h0, 2'h0);
      axr(32'h0, 8'h00, SLV);
      axw(32'h4, 8'h00, SLV);
      chk_st(1'b0, 20'h00000, 8'h00);
      for (i = 0; i < 9; i++)
      begin
         rst(2'(i / 3), 2'(i % 3));
         pin_q <= 1'b1;
         repeat (12) @(posedge aclk);
         r = rnd();
         up_q <= r[1:0];
         lo_q <= r[3:2];
         oe_q <= r[11:4];
         chk_st(1'b0, exp_run(20'hFFFFF, r[11:4]), atab[i]);
      end
      axr(32'h0, `CCOE_RST_OECR_HI, OK);
      axr(32'h1C, `CCOE_RST_BYTE_CNT, OK);
      axr(32'h20, `CCOE_RST_MASK, OK);
      axr(32'h2C, 8'h00, SLV);
      for (i = 0; i < 4; i++)
      begin
         r = rnd();
         en_v = r[19:0];
         oe_q <= r[27:20];
         wr20(32'h0, en_v);
         axr(32'h4, en_v[7:0], OK);
         axr(32'hC, oe_q, OK);
         chk_st(1'b0, exp_run(en_v, r[27:20]), 8'hCE);
      end
      pin_q <= 1'b0;
      chk_st(1'b1, 20'h00000, 8'hCE);
      axw(32'h4, ~en_v[7:0], SLV);
      pin_q <= 1'b1;
      chk_st(1'b0, exp_run(en_v, oe_q), 8'hCE);
      r = rnd();
      mk_v = r[19:0];
      wr20(32'h20, mk_v);
      pin_q <= 1'b0;
      sel_q <= 1'b1;
      r = rnd();
      oe_q <= r[7:0];
      sb.send(r[27:8], 1'b0);
      @(posedge aclk);
      pin_q <= 1'b1;
      chk_st(1'b0, r[27:8] | mk_v, 8'hCE);
      axr(32'h10, 8'h01, OK);
      r = rnd();
      sb.send(r[19:0], 1'b1);
      @(posedge aclk);
      chk_st(1'b0, r[19:0] | mk_v, 8'hCE);
      sel_q <= 1'b0;
      chk_st(1'b0, exp_run(en_v, oe_q), 8'hCE);
      stop_test();
   end
endmodule
